// [rtl/blit_pixel_stage.sv]
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// RL1 - key colour masked by colour depth
// RL2 - fill colour driven for solid fill
// RL3 - start position only for 1-bit expansion
// RL4 - start is address bit 0 plus setting
// RL5 - software keeps start zero for wide indices
// RL6 - expansion runs from most significant field
// RL7 - 1-bit source word is byte swapped
// RL8 - wider index fields are bit reversed
// RL9 - format field selects 1/2/4/8-bit indices
// RL10 - blending uses its own source format
// RL11 - blend formats 1555, 4444, 8888 onto 565
// RL12 - eight-bit constant alpha is held
// RL13 - constant alpha bit 0 is ignored
// RL14 - output is weighted sum of both colours
// RL15 - selectors in bits 9-8 and 1-0
// RL16 - software uses complementary selector pairs
// RL17 - selector decodes alpha, inverse, constant, inverse
// RL18 - reserved blend format gives undefined output
module blit_pixel_stage (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic [17:0]                paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire blit_pixel_pkg::engine_in_t eng_in,
	output var blit_pixel_pkg::engine_out_t eng_out
);
	import blit_pixel_pkg::*;

	state_t st;       // Present state, all in flip-flops.
	state_t next_st;  // Value the state takes at the next edge.

	// Widen a narrow channel to eight bits by repeating its top bits.
	function automatic logic [7:0] widen5(input logic [4:0] c);
		return {c, c[4:2]};
	endfunction : widen5

	function automatic logic [7:0] widen6(input logic [5:0] c);
		return {c, c[5:4]};
	endfunction : widen6

	// Mix one channel; the sum is scaled by 1/256 and saturates.
	function automatic logic [7:0] mix(input logic [7:0] sa,
		input logic [7:0] sc, input logic [7:0] da, input logic [7:0] dc);
		logic [15:0] p;
		logic [15:0] q;
		logic [16:0] s;
		p = 16'(sa) * 16'(sc);
		q = 16'(da) * 16'(dc);
		s = 17'(p) + 17'(q);
		return s[16] ? 8'hff : s[15:8];
	endfunction : mix

	// Pick one blend factor from a two-bit selector.
	function automatic logic [7:0] factor(input logic [1:0] sel,
		input logic [7:0] pix_a, input logic [7:0] con_a);
		logic [7:0] f;
		f = 8'h00;
		// RL17 selector decode
		case (sel)
			SEL_ALPHA:     f = pix_a;
			SEL_INV_ALPHA: f = 8'hff - pix_a;
			SEL_CONST:     f = con_a;
			SEL_INV_CONST: f = 8'hff - con_a;
			default:       f = 8'h00;
		endcase
		return f;
	endfunction : factor

	// Reverse the bit order of a byte.
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction : rev8

	// Combinational helpers of the register decode and the pixel path.
	logic [15:0] reg_index;     // Register index from the byte address.
	logic        addr_hit;      // Address names a mapped register.
	logic [31:0] read_word;     // Read data of the addressed register.
	logic [3:0]  eff_start;     // Address bit 0 plus programmed start.
	logic        start_apply;   // Start position is honoured.
	logic [15:0] shifted;       // Source word moved to the active field.
	logic [7:0]  index;         // Lookup index of the current slot.
	logic [7:0]  src_a;         // Source channels widened to eight bits.
	logic [7:0]  src_r;
	logic [7:0]  src_g;
	logic [7:0]  src_b;
	logic [7:0]  con_a;         // Constant alpha with bit 0 dropped.
	logic [7:0]  fa_src;        // Source factor.
	logic [7:0]  fa_dst;        // Destination factor.
	logic [7:0]  out_r;
	logic [7:0]  out_g;
	logic [7:0]  out_b;

	assign reg_index = paddr[17:2];

	// Address decode and read multiplexer of the register file.
	always_comb begin
		addr_hit  = 1'b1;
		read_word = 32'h0000_0000;
		case (reg_index)
			IDX_KEY_COLOR_LOW:   read_word = {16'h0000, st.regs.key[15:0]};
			IDX_KEY_COLOR_HIGH:  read_word = {16'h0000, st.regs.key[31:16]};
			IDX_FILL_COLOR_LOW:  read_word = {16'h0000, st.regs.fill[15:0]};
			IDX_FILL_COLOR_HIGH: read_word = {16'h0000, st.regs.fill[31:16]};
			IDX_EXPAND_START:    read_word = {29'h0, st.regs.start};
			IDX_EXPAND_FORMAT:   read_word = {30'h0, st.regs.exp_fmt};
			IDX_BLEND_FORMAT:    read_word = {30'h0, st.regs.blend_fmt};
			IDX_CONSTANT_ALPHA:  read_word = {24'h0, st.regs.const_alpha};
			IDX_ALPHA_SELECT: begin
				read_word = {22'h0, st.regs.dst_sel, 6'h00, st.regs.src_sel};
			end
			// Read-only view of what the pixel path is using now.
			IDX_ENGINE_STATUS: begin
				read_word = {27'h0, st.eng.fill_active, st.eng.start_position};
			end
			default: addr_hit = 1'b0;
		endcase
	end

	// Expansion start position and lookup index of one slot.
	always_comb begin
		// RL4 start position sum
		eff_start   = 4'(eng_in.src_addr0) + 4'(st.regs.start);
		// RL3 start position gating
		start_apply = eng_in.expand_en && (st.regs.exp_fmt == EXP_1BIT)
			&& (eng_in.opcode == OP_WRITE || eng_in.opcode == OP_MOVE);
		shifted = 16'h0000;
		index   = 8'h00;
		// RL6 most significant field first
		// RL9 index format decode
		case (st.regs.exp_fmt)
			EXP_1BIT: begin
				// RL7 byte swap for 1-bit
				shifted = {eng_in.src_word[7:0], eng_in.src_word[15:8]}
					<< (eng_in.slot + (start_apply ? eff_start : 4'h0));
				index = {7'h00, shifted[15]};
			end
			EXP_2BIT: begin
				// RL8 reversed 2-bit field
				shifted = eng_in.src_word << {eng_in.slot[2:0], 1'b0};
				index = {6'h00, shifted[14], shifted[15]};
			end
			EXP_4BIT: begin
				// RL8 reversed 4-bit field
				shifted = eng_in.src_word << {eng_in.slot[1:0], 2'b00};
				index = {4'h0, shifted[12], shifted[13], shifted[14], shifted[15]};
			end
			EXP_8BIT: begin
				// RL8 reversed 8-bit field
				shifted = eng_in.src_word << {eng_in.slot[0], 3'b000};
				index = rev8(shifted[15:8]);
			end
			default: index = 8'h00;
		endcase
	end

	// Blend datapath: source channels, factors and weighted sum.
	always_comb begin
		src_a = 8'h00;
		src_r = 8'h00;
		src_g = 8'h00;
		src_b = 8'h00;
		// RL10 blend format used
		// RL11 blend format decode
		case (st.regs.blend_fmt)
			BLEND_1555: begin
				src_a = eng_in.src_pixel[15] ? 8'hff : 8'h00;
				src_r = widen5(eng_in.src_pixel[14:10]);
				src_g = widen5(eng_in.src_pixel[9:5]);
				src_b = widen5(eng_in.src_pixel[4:0]);
			end
			BLEND_4444: begin
				src_a = {2{eng_in.src_pixel[15:12]}};
				src_r = {2{eng_in.src_pixel[11:8]}};
				src_g = {2{eng_in.src_pixel[7:4]}};
				src_b = {2{eng_in.src_pixel[3:0]}};
			end
			BLEND_8888: begin
				src_a = eng_in.src_pixel[31:24];
				src_r = eng_in.src_pixel[23:16];
				src_g = eng_in.src_pixel[15:8];
				src_b = eng_in.src_pixel[7:0];
			end
			// RL18 reserved format output
			default: src_a = 8'h00;
		endcase
		// RL13 constant alpha lsb dropped
		con_a  = {st.regs.const_alpha[7:1], 1'b0};
		// RL12 constant alpha combined
		fa_src = factor(st.regs.src_sel, src_a, con_a);
		fa_dst = factor(st.regs.dst_sel, src_a, con_a);
		// RL14 weighted channel sum
		out_r = mix(fa_src, src_r, fa_dst, widen5(eng_in.dst_pixel[15:11]));
		out_g = mix(fa_src, src_g, fa_dst, widen6(eng_in.dst_pixel[10:5]));
		out_b = mix(fa_src, src_b, fa_dst, widen5(eng_in.dst_pixel[4:0]));
	end

	// Next state: bus slave with one wait state, then the pixel results.
	// The wait state lets the read data come from a flip-flop.
	always_comb begin
		next_st = st;
		next_st.pready  = 1'b0;
		next_st.pslverr = 1'b0;
		if (psel && penable && !st.pready) begin
			// First access cycle: answer at the next edge.
			next_st.pready  = 1'b1;
			next_st.pslverr = !addr_hit;
			next_st.prdata  = pwrite ? 32'h0000_0000 : read_word;
		end
		if (psel && penable && st.pready && pwrite) begin
			// Writes take effect on the edge that completes the transfer.
			case (reg_index)
				IDX_KEY_COLOR_LOW:   next_st.regs.key[15:0]   = pwdata[15:0];
				IDX_KEY_COLOR_HIGH:  next_st.regs.key[31:16]  = pwdata[15:0];
				IDX_FILL_COLOR_LOW:  next_st.regs.fill[15:0]  = pwdata[15:0];
				IDX_FILL_COLOR_HIGH: next_st.regs.fill[31:16] = pwdata[15:0];
				IDX_EXPAND_START: begin
					next_st.regs.start = pwdata[START_POS_MSB:0];
				end
				IDX_EXPAND_FORMAT: begin
					next_st.regs.exp_fmt = pwdata[FORMAT_MSB:0];
				end
				IDX_BLEND_FORMAT: begin
					next_st.regs.blend_fmt = pwdata[FORMAT_MSB:0];
				end
				IDX_CONSTANT_ALPHA: begin
					next_st.regs.const_alpha = pwdata[CONST_ALPHA_MSB:0];
				end
				// RL15 selector fields
				IDX_ALPHA_SELECT: begin
					next_st.regs.dst_sel = pwdata[DST_SEL_LSB +: 2];
					next_st.regs.src_sel = pwdata[SRC_SEL_LSB +: 2];
				end
				default: next_st.regs = st.regs;
			endcase
		end
		// RL1 key colour depth mask
		case (eng_in.depth)
			DEPTH_32: next_st.eng.key_color = st.regs.key;
			DEPTH_16: next_st.eng.key_color = {16'h0000, st.regs.key[15:0]};
			default:  next_st.eng.key_color = {24'h0, st.regs.key[7:0]};
		endcase
		// RL2 fill colour for fill
		next_st.eng.fill_active = (eng_in.opcode == OP_FILL);
		case (eng_in.depth)
			DEPTH_32: next_st.eng.fill_color = st.regs.fill;
			DEPTH_16: next_st.eng.fill_color = {16'h0000, st.regs.fill[15:0]};
			default:  next_st.eng.fill_color = {24'h0, st.regs.fill[7:0]};
		endcase
		if (eng_in.opcode != OP_FILL) begin
			next_st.eng.fill_color = 32'h0000_0000;
		end
		// RL3 start position output
		next_st.eng.start_position = start_apply ? eff_start : 4'h0;
		next_st.eng.lut_index      = index;
		// Without blending the destination passes through untouched.
		next_st.eng.blend_pixel = eng_in.blend_en
			? {out_r[7:3], out_g[7:2], out_b[7:3]} : eng_in.dst_pixel;
	end

	// State register; reset leaves everything at its documented value.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.regs.key  <= COLOR_RESET;
			st.regs.fill <= COLOR_RESET;
			st.regs.dst_sel <= ALPHA_SELECT_RESET[DST_SEL_LSB +: 2];
			st.regs.src_sel <= ALPHA_SELECT_RESET[SRC_SEL_LSB +: 2];
		end else begin
			st <= next_st;
		end
	end

	assign prdata  = st.prdata;
	assign pready  = st.pready;
	assign pslverr = st.pslverr;
	assign eng_out = st.eng;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_key_depth16: assert property ( // RL1
		eng_in.depth == DEPTH_16 |=> eng_out.key_color[31:16] == 16'h0000)
		else $error("key colour upper half not cleared at 16 bpp");

	a_key_depth8: assert property ( // RL1
		eng_in.depth == DEPTH_8
		|=> eng_out.key_color == {24'h0, $past(st.regs.key[7:0])})
		else $error("key colour not reduced to one byte at 8 bpp");

	a_fill_select: assert property ( // RL2
		eng_in.opcode == OP_FILL && eng_in.depth == DEPTH_32
		|=> eng_out.fill_active && eng_out.fill_color == $past(st.regs.fill))
		else $error("fill colour not presented for solid fill");

	a_start_gate: assert property ( // RL3
		!eng_in.expand_en || st.regs.exp_fmt != EXP_1BIT
		|=> eng_out.start_position == 4'h0)
		else $error("start position applied outside 1-bit expansion");

	a_start_sum: assert property ( // RL4
		start_apply |=> eng_out.start_position
			== 4'($past(eng_in.src_addr0)) + 4'($past(st.regs.start)))
		else $error("start position is not address bit plus setting");

	a_index_2bit: assert property ( // RL8
		st.regs.exp_fmt == EXP_2BIT && eng_in.slot == 4'h0
		|=> eng_out.lut_index
			== {6'h00, $past(eng_in.src_word[14]), $past(eng_in.src_word[15])})
		else $error("2-bit index not bit reversed");

	a_index_1bit: assert property ( // RL7
		st.regs.exp_fmt == EXP_1BIT && !eng_in.expand_en
		&& eng_in.slot == 4'h0
		|=> eng_out.lut_index == {7'h00, $past(eng_in.src_word[7])})
		else $error("1-bit index not taken from swapped byte");

	a_blend_bypass: assert property ( // RL10
		!eng_in.blend_en |=> eng_out.blend_pixel == $past(eng_in.dst_pixel))
		else $error("destination altered with blending off");

	a_bus_answer: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("bus answer is not a single-cycle pulse");

	a_fill_idle: assert property ( // RL2
		eng_in.opcode != OP_FILL
		|=> !eng_out.fill_active && eng_out.fill_color == 32'h0000_0000)
		else $error("fill colour presented outside solid fill");

	a_fill_depth16: assert property ( // RL2
		eng_in.opcode == OP_FILL && eng_in.depth == DEPTH_16
		|=> eng_out.fill_color == {16'h0000, $past(st.regs.fill[15:0])})
		else $error("fill colour not reduced to low half at 16 bpp");

	a_index_narrow: assert property ( // RL9
		st.regs.exp_fmt == EXP_4BIT |=> eng_out.lut_index[7:4] == 4'h0)
		else $error("4-bit index wider than its field");

	a_index_single: assert property ( // RL9
		st.regs.exp_fmt == EXP_1BIT |=> eng_out.lut_index[7:1] == 7'h00)
		else $error("1-bit index wider than its field");

	// A constant alpha of zero or one must blank both weighted terms.
	a_blend_zero: assert property ( // RL14
		eng_in.blend_en && st.regs.src_sel == SEL_CONST
		&& st.regs.dst_sel == SEL_CONST && st.regs.const_alpha[7:1] == 7'h00
		|=> eng_out.blend_pixel == 16'h0000)
		else $error("zero constant alpha does not give a black pixel");

	a_bus_mapped: assert property (
		psel && penable && !pready && reg_index == IDX_ALPHA_SELECT
		|=> pready && !pslverr)
		else $error("mapped register answered with an error");

	// Main scenarios that the bench is expected to reach.
	c_fill_op: cover property (eng_in.opcode == OP_FILL ##1 eng_out.fill_active);
	c_index_8bit: cover property (st.regs.exp_fmt == EXP_8BIT
		&& eng_in.expand_en);
	c_blend_on: cover property (eng_in.blend_en
		&& st.regs.blend_fmt == BLEND_8888);
	c_write_done: cover property (psel && penable && pready && pwrite);
	c_expand_start: cover property (start_apply && eff_start != 4'h0);

endmodule : blit_pixel_stage
`default_nettype wire

// [inc/blit_pixel_pkg.sv]
`default_nettype none
// Shared constants and carriers of the block-transfer pixel stage.
package blit_pixel_pkg;

	// Register indices; the bus byte address is four times the index.
	localparam logic [15:0] IDX_KEY_COLOR_LOW       = 16'h1850;
	localparam logic [15:0] IDX_KEY_COLOR_HIGH      = 16'h1852;
	localparam logic [15:0] IDX_FILL_COLOR_LOW      = 16'h1854;
	localparam logic [15:0] IDX_FILL_COLOR_HIGH     = 16'h1856;
	localparam logic [15:0] IDX_EXPAND_START        = 16'h1860;
	localparam logic [15:0] IDX_EXPAND_FORMAT       = 16'h1862;
	localparam logic [15:0] IDX_BLEND_FORMAT        = 16'h1870;
	localparam logic [15:0] IDX_CONSTANT_ALPHA      = 16'h1872;
	localparam logic [15:0] IDX_ALPHA_SELECT        = 16'h1874;
	localparam logic [15:0] IDX_ENGINE_STATUS       = 16'h1878;

	// Field positions inside the registers.
	localparam int START_POS_MSB   = 2;
	localparam int FORMAT_MSB      = 1;
	localparam int CONST_ALPHA_MSB = 7;
	localparam int DST_SEL_LSB     = 8;
	localparam int SRC_SEL_LSB     = 0;

	// Values after reset.
	localparam logic [15:0] ALPHA_SELECT_RESET = 16'h0001;
	localparam logic [31:0] COLOR_RESET        = 32'h0000_0000;

	// Colour depth codes of the engine.
	localparam logic [1:0] DEPTH_8  = 2'h0;
	localparam logic [1:0] DEPTH_16 = 2'h1;
	localparam logic [1:0] DEPTH_32 = 2'h2;

	// Operation codes of the engine.
	localparam logic [2:0] OP_WRITE = 3'h0;
	localparam logic [2:0] OP_MOVE  = 3'h2;
	localparam logic [2:0] OP_FILL  = 3'h3;

	// Expansion index formats.
	localparam logic [1:0] EXP_1BIT = 2'h0;
	localparam logic [1:0] EXP_2BIT = 2'h1;
	localparam logic [1:0] EXP_4BIT = 2'h2;
	localparam logic [1:0] EXP_8BIT = 2'h3;

	// Blend source formats.
	localparam logic [1:0] BLEND_1555 = 2'h0;
	localparam logic [1:0] BLEND_4444 = 2'h1;
	localparam logic [1:0] BLEND_8888 = 2'h2;

	// Alpha factor selectors.
	localparam logic [1:0] SEL_ALPHA       = 2'h0;
	localparam logic [1:0] SEL_INV_ALPHA   = 2'h1;
	localparam logic [1:0] SEL_CONST       = 2'h2;
	localparam logic [1:0] SEL_INV_CONST   = 2'h3;

	// Inputs from the rest of the transfer engine.
	typedef struct packed {
		logic [1:0]  depth;
		logic [2:0]  opcode;
		logic        expand_en;
		logic        blend_en;
		logic        src_addr0;
		logic [15:0] src_word;
		logic [3:0]  slot;
		logic [31:0] src_pixel;
		logic [15:0] dst_pixel;
	} engine_in_t;

	// Results handed back to the transfer engine.
	typedef struct packed {
		logic [31:0] key_color;
		logic [31:0] fill_color;
		logic        fill_active;
		logic [3:0]  start_position;
		logic [7:0]  lut_index;
		logic [15:0] blend_pixel;
	} engine_out_t;

	// Software-visible settings.
	typedef struct packed {
		logic [31:0] key;
		logic [31:0] fill;
		logic [2:0]  start;
		logic [1:0]  exp_fmt;
		logic [1:0]  blend_fmt;
		logic [7:0]  const_alpha;
		logic [1:0]  dst_sel;
		logic [1:0]  src_sel;
	} regs_t;

	// Whole state of the block.
	typedef struct packed {
		regs_t       regs;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		engine_out_t eng;
	} state_t;

endpackage : blit_pixel_pkg
`default_nettype wire

// [tb/blit_color_expand_alpha_blend_tb.sv]
`timescale 1ns/100ps
`default_nettype none
// Counts every comparison and reports a mismatch at once.
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
num_errors++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module blit_color_expand_alpha_blend_tb;
	import blit_pixel_pkg::*;

	logic        pclk = 1'b0;      // Bus and pixel clock.
	logic        presetn = 1'b0;   // Held low for the first cycles.
	logic [17:0] paddr = 18'h0;    // Byte address of the access.
	logic        psel = 1'b0;      // Select of the bus cycle.
	logic        penable = 1'b0;   // Access phase marker.
	logic        pwrite = 1'b0;    // Direction of the bus cycle.
	logic [31:0] pwdata = 32'h0;   // Write data.
	logic [31:0] prdata;           // Read data from the block.
	logic        pready;           // Completion of an access.
	logic        pslverr;          // Error of an access.
	engine_in_t  eng_in = '0;      // Engine side stimulus.
	engine_out_t eng_out;          // Engine side results.
	int          num_errors = 0;   // Mismatches seen.
	int          total_checks = 0; // Comparisons made.
	logic [31:0] rd;               // Read data of the last access.
	logic        err;              // Error of the last access.
	// Register indices and the bits that each one stores.
	logic [15:0] idx_t [9] = '{IDX_KEY_COLOR_LOW, IDX_KEY_COLOR_HIGH,
		IDX_FILL_COLOR_LOW, IDX_FILL_COLOR_HIGH, IDX_EXPAND_START,
		IDX_EXPAND_FORMAT, IDX_BLEND_FORMAT, IDX_CONSTANT_ALPHA,
		IDX_ALPHA_SELECT};
	logic [31:0] msk_t [9] = '{32'hffff, 32'hffff, 32'hffff, 32'hffff,
		32'h7, 32'h3, 32'h3, 32'hff, 32'h303};

	// Half period of 2.5 ns gives 200 MHz.
	always #2.5 pclk = ~pclk;

	blit_pixel_stage dut_u (
		.pclk    (pclk),
		.presetn (presetn),
		.paddr   (paddr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.eng_in  (eng_in),
		.eng_out (eng_out)
	);

	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	// One bus cycle; the request is held until pready is seen high.
	task automatic apb(input logic wr, input logic [15:0] idx,
		input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// A missing answer must not hang the run.
		if (n >= 20) begin
			$display("[FAIL] %0t no bus answer", $time);
			num_errors++;
			wrap_up();
		end
	endtask : apb

	// Applies engine inputs and waits past the one-cycle latency.
	task automatic drive(input engine_in_t v);
		@(posedge pclk);
		eng_in <= v;
		@(posedge pclk);
		#1;
	endtask : drive

	// Colour bits kept for a given depth code.
	function automatic logic [31:0] dmask(input logic [1:0] d);
		return (d == DEPTH_32) ? 32'hffffffff :
			(d == DEPTH_16) ? 32'h0000ffff : 32'h000000ff;
	endfunction : dmask

	// Lookup index of a slot, fields taken from the top down.
	function automatic logic [7:0] xidx(input logic [15:0] w,
		input logic [1:0] f, input int s);
		logic [15:0] sw;
		logic [7:0]  r;
		int          bw;
		sw = {w[7:0], w[15:8]};
		bw = 1 << f;
		r = 8'h0;
		if (f == EXP_1BIT) begin
			r[0] = sw[15 - s];
		end else begin
			for (int i = 0; i < bw; i++) r[i] = w[15 - s * bw - i];
		end
		return r;
	endfunction : xidx

	// Blend factor for one selector code.
	function automatic logic [7:0] fac(input logic [1:0] sel,
		input logic [7:0] a, input logic [7:0] c);
		return (sel == SEL_ALPHA) ? a : (sel == SEL_INV_ALPHA) ? ~a :
			(sel == SEL_CONST) ? c : ~c;
	endfunction : fac

	// Weighted sum of one channel, saturated to eight bits.
	function automatic logic [7:0] mix(input logic [7:0] fs,
		input logic [7:0] cs, input logic [7:0] fd, input logic [7:0] cd);
		logic [16:0] t;
		t = fs * cs + fd * cd;
		return (t[16:8] > 9'd255) ? 8'hff : t[15:8];
	endfunction : mix

	// Expected 5:6:5 result of blending one source onto one destination.
	function automatic logic [15:0] xblend(input logic [31:0] s,
		input logic [15:0] d, input logic [1:0] f, input logic [7:0] ca,
		input logic [1:0] ss, input logic [1:0] ds);
		logic [7:0] a, r, g, b, c, fs, fd;
		if (f == BLEND_1555) begin
			a = {8{s[15]}};
			r = {s[14:10], s[14:12]};
			g = {s[9:5], s[9:7]};
			b = {s[4:0], s[4:2]};
		end else if (f == BLEND_4444) begin
			a = {2{s[15:12]}};
			r = {2{s[11:8]}};
			g = {2{s[7:4]}};
			b = {2{s[3:0]}};
		end else begin
			{a, r, g, b} = s;
		end
		c = {ca[7:1], 1'b0};
		fs = fac(ss, a, c);
		fd = fac(ds, a, c);
		r = mix(fs, r, fd, {d[15:11], d[15:13]});
		g = mix(fs, g, fd, {d[10:5], d[10:9]});
		b = mix(fs, b, fd, {d[4:0], d[4:2]});
		return {r[7:3], g[7:2], b[7:3]};
	endfunction : xblend

	// Main sequence: registers, colours, expansion, then blending.
	initial begin
		engine_in_t  e;
		logic [31:0] kv, fv, v;
		logic [15:0] w;
		logic [7:0]  ca;
		logic [2:0]  st;
		logic [3:0]  sp;
		void'($urandom(28));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, idx_t[i], 32'h0);
			`CHK(rd, (i == 8) ? 32'h1 : 32'h0)
			v = $urandom();
			apb(1'b1, idx_t[i], v);
			apb(1'b0, idx_t[i], 32'h0);
			`CHK(rd, v & msk_t[i])
			`CHK(err, 1'b0)
		end
		// An unmapped index answers with an error and no data.
		apb(1'b1, 16'h1864, 32'hffffffff);
		`CHK(err, 1'b1)
		apb(1'b0, 16'h1864, 32'h0);
		`CHK(rd, 32'h0)
		kv = $urandom();
		fv = $urandom();
		apb(1'b1, IDX_KEY_COLOR_LOW, {16'h0, kv[15:0]});
		apb(1'b1, IDX_KEY_COLOR_HIGH, {16'h0, kv[31:16]});
		apb(1'b1, IDX_FILL_COLOR_LOW, {16'h0, fv[15:0]});
		apb(1'b1, IDX_FILL_COLOR_HIGH, {16'h0, fv[31:16]});
		for (int k = 0; k < 32; k++) begin
			e = 76'({$urandom(), $urandom(), $urandom()});
			e.depth = k[1:0];
			e.opcode = k[4:2];
			drive(e);
			`CHK(eng_out.key_color, kv & dmask(k[1:0]))
			v = (k[4:2] == OP_FILL) ? fv & dmask(k[1:0]) : 32'h0;
			`CHK(eng_out.fill_color, v)
			`CHK(eng_out.fill_active, k[4:2] == OP_FILL)
		end
		for (int p = 0; p < 3; p++) begin
			st = (p == 0) ? 3'h7 : 3'($urandom());
			apb(1'b1, IDX_EXPAND_FORMAT, (p == 2) ? 32'h1 : 32'h0);
			apb(1'b1, IDX_EXPAND_START, {29'h0, st});
			for (int k = 0; k < 32; k++) begin
				e = 76'({$urandom(), $urandom(), $urandom()});
				{e.opcode, e.src_addr0, e.expand_en} = k[4:0];
				drive(e);
				sp = (k[0] && p != 2 && (e.opcode == OP_WRITE
					|| e.opcode == OP_MOVE)) ? {1'b0, st} + 4'(k[1]) : 4'h0;
				`CHK(eng_out.start_position, sp)
				// The status view mirrors what the pixel path uses now.
				apb(1'b0, IDX_ENGINE_STATUS, 32'h0);
				`CHK(rd, {27'h0, e.opcode == OP_FILL, sp})
			end
		end
		apb(1'b1, IDX_EXPAND_START, 32'h0);
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, IDX_EXPAND_FORMAT, 32'(f));
			for (int n = 0; n < 5; n++) begin
				w = (n == 0) ? 16'h1234 : 16'($urandom());
				for (int s = 0; s < (16 >> f); s++) begin
					e = 76'({$urandom(), $urandom(), $urandom()});
					e.expand_en = 1'b1;
					e.opcode = OP_WRITE;
					e.src_addr0 = 1'b0;
					e.src_word = w;
					e.slot = 4'(s);
					drive(e);
					`CHK(eng_out.lut_index, xidx(w, 2'(f), s))
				end
			end
		end
		for (int f = 0; f < 3; f++) begin
			apb(1'b1, IDX_BLEND_FORMAT, 32'(f));
			for (int sl = 0; sl < 16; sl++) begin
				ca = (sl == 0 || sl == 10) ? 8'h01 : 8'($urandom());
				apb(1'b1, IDX_CONSTANT_ALPHA, {24'h0, ca});
				apb(1'b1, IDX_ALPHA_SELECT, {22'h0, sl[3:2], 6'h0, sl[1:0]});
				repeat (3) begin
					e = 76'({$urandom(), $urandom(), $urandom()});
					e.blend_en = 1'b1;
					drive(e);
					w = xblend(e.src_pixel, e.dst_pixel, 2'(f), ca, sl[1:0],
						sl[3:2]);
					`CHK(eng_out.blend_pixel, w)
					e.blend_en = 1'b0;
					drive(e);
					`CHK(eng_out.blend_pixel, e.dst_pixel)
				end
			end
		end
		wrap_up();
	end

endmodule : blit_color_expand_alpha_blend_tb
`default_nettype wire
